/* src/spm_buf2.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module spm_buf2 #(
	parameter int WIDTH = 1 // word width
) (
	input  wire logic             clk_sys,   // system clock
	input  wire logic             rst_n,     // synchronised reset, active low
	input  wire logic             ce,        // clock enable
	input  wire logic             flush,     // drop all entries
	input  wire logic             in_valid,  // word offered
	input  wire logic [WIDTH-1:0] in_data,   // offered word
	output var  logic             in_ready,  // room for a word
	output var  logic             out_valid, // head word valid
	output var  logic [WIDTH-1:0] out_data,  // head word
	input  wire logic             out_ready  // head word taken
);

	logic             v1_q; // second entry valid
	logic [WIDTH-1:0] d1_q; // second entry word
	logic             push; // word accepted
	logic             pop;  // head consumed

	// ready only from a flop, so the filler never sees a combinational path
	assign in_ready = ~v1_q;
	assign push     = in_valid & in_ready;
	assign pop      = out_valid & out_ready;

	// head entry feeds the output directly, second entry absorbs a stall
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_valid <= 1'b0;
			out_data  <= '0;
			v1_q      <= 1'b0;
			d1_q      <= '0;
		end
		else if (ce)
		begin
			if (flush)
			begin
				out_valid <= 1'b0;
				v1_q      <= 1'b0;
			end
			else if (!out_valid || pop)
			begin
				// head free: refill from second entry first to keep order
				if (v1_q)
				begin
					out_valid <= 1'b1;
					out_data  <= d1_q;
					v1_q      <= 1'b0;
				end
				else
				begin
					out_valid <= push;
					out_data  <= in_data;
				end
			end
			else if (push)
			begin
				v1_q <= 1'b1;
				d1_q <= in_data;
			end
		end
	end

endmodule : spm_buf2
`default_nettype wire

/* src/spm_cfg.svh */
// constants for the scratchpad memory command logic
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// memory function command bytes
`define SPM_CMD_WRITE_SCR 8'h0F
`define SPM_CMD_READ_SCR  8'hAA
`define SPM_CMD_COPY_SCR  8'h55
`define SPM_CMD_READ_MEM  8'hF0

// storage geometry
`define SPM_SCR_LAST      5'h1F
`define SPM_MEM_BYTES     18'h0_2000

// status byte field positions
`define SPM_ES_PF_BIT     5
`define SPM_ES_OF_BIT     6
`define SPM_ES_AA_BIT     7

// reset values
`define SPM_TA_RESET      8'h00
`define SPM_END_RESET     5'h00

// read-scratchpad index of last preamble byte and filler bytes
`define SPM_HDR_LAST      14'h0002
`define SPM_BYTE_ONES     8'hFF
`define SPM_BYTE_ZERO     8'h00

// identity crc: reflected form of x^8 + x^5 + x^4 + 1
`define SPM_CRC_POLY      8'h8C
`define SPM_ROM_DATA_BITS 6'h38

`endif

/* src/spm_crc8.sv */
// serial identity crc generator
`timescale 1ns/1ps
`default_nettype none
`include "spm_cfg.svh"

module spm_crc8 (
	input  wire logic       clk_sys, // system clock
	input  wire logic       rst_n,   // synchronised reset, active low
	input  wire logic       ce,      // clock enable
	input  wire logic       shift,   // shift one bit in
	input  wire logic       din,     // bit to shift, lsb first
	output var  logic [7:0] crc_q    // register contents
);

	logic fb; // feedback term

	assign fb = din ^ crc_q[0];

	// shift register with xor taps, starts at zero
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			crc_q <= 8'h00;
		else if (ce && shift)
			crc_q <= {1'b0, crc_q[7:1]} ^ (fb ? `SPM_CRC_POLY : 8'h00);
	end

	property p_crc_step;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && shift && !fb) |=> (crc_q == {1'b0, $past(crc_q[7:1])});
	endproperty
	a_crc_step: assert property (p_crc_step) else $error("crc shifted wrongly without feedback");

endmodule : spm_crc8
`default_nettype wire

/* src/spm_pkg.sv */
// types shared by the scratchpad memory command logic
package spm_pkg;

	typedef logic [7:0] spm_byte_t;

	typedef enum logic [3:0] {
		SPM_IDLE,
		SPM_CMD,
		SPM_TA1,
		SPM_TA2,
		SPM_WDATA,
		SPM_RSCR,
		SPM_AUTH,
		SPM_COPY,
		SPM_DONE0,
		SPM_RMEM,
		SPM_HALT
	} spm_state_e;

endpackage : spm_pkg

/* src/spm_top.sv */
// command, scratchpad and identity logic of the serial memory slave
//
// Summary of operation
// - identity rom: family, serial, crc over 56
// - crc polynomial x8 + x5 + x4 + 1
// - crc starts zero, family lsb first
// - shifting stored crc returns zero
// - memory commands only after rom command
// - overdrive rom command switches to high speed
// - all bytes travel lsb first
// - 256 pages of 32 bytes plus scratchpad
// - status low five bits: ending offset
// - bit 5 flags partial byte written
// - bit 6 flags scratchpad overflow
// - bit 7 copied flag, cleared by write
// - status byte read only to master
// - address low five bits give offset
// - write: address, data, record ending offset
// - read scratch: address, status, data
// - reads past scratchpad end return ones until 14-bit position wraps
// - copy: master echoes address and status
// - regular speed default, overdrive when switched
// - copy only on exact three-byte match
// - zeros after copy, resets ignored during
// - read memory streams to end, ones
// - copy offset through ending offset bytes
`timescale 1ns/1ps
`default_nettype none
`include "spm_cfg.svh"

module spm_top import spm_pkg::*; #(
	parameter logic [7:0]  FAMILY_CODE   = 8'h5A,              // arbitrary value
	parameter logic [47:0] SERIAL_NUMBER = 48'h0123_4567_89AB  // arbitrary value
) (
	input  wire logic        clk_sys,              // system clock, 125 MHz
	input  wire logic        rst_b,                // async reset, active low
	input  wire logic        ce,                   // clock enable, freezes state when low
	input  wire logic        bus_reset,            // pulse: bus reset pulse seen
	input  wire logic        bus_reset_slow,       // with bus_reset: pulse had regular length
	input  wire logic        rom_cmd_done,         // pulse: rom function command succeeded
	input  wire logic        rom_od_cmd,           // pulse: overdrive rom command byte seen
	input  wire logic        rx_valid,             // pulse: master wrote one bit
	input  wire logic        rx_bit,               // written bit value
	input  wire logic        tx_ready,             // read slot takes the head bit
	output var  logic        tx_valid,             // a bit is ready to send
	output var  logic        tx_bit,               // bit to send
	output var  logic        speed_select_flag,    // 1 = overdrive speed
	output var  logic [7:0]  target_address_low,   // address register, low byte
	output var  logic [7:0]  target_address_high,  // address register, high byte
	output var  logic [7:0]  ending_offset_status, // status byte
	output var  logic [63:0] rom_code,             // identity rom
	output var  logic        rom_valid             // identity rom complete
);

	logic [1:0]  rst_sync_q;          // reset release synchroniser
	logic        rst_n;               // synchronised reset
	spm_state_e  state_q;             // command state
	spm_byte_t   cmd_q;               // last memory command
	spm_byte_t   rx_sh_q;             // receive shift register
	logic [2:0]  rx_cnt_q;            // bits of current byte received
	logic [2:0]  tx_cnt_q;            // bit index of byte being sent
	logic [13:0] idx_q;               // byte index of answer stream
	logic [4:0]  end_q;               // ending offset
	logic        pf_q;                // partial byte flag
	logic        of_q;                // overflow flag
	logic        aa_q;                // authorization accepted flag
	logic [5:0]  wr_pos_q;            // scratchpad write position, bit 5 = full
	logic [1:0]  auth_cnt_q;          // authorization byte count
	logic        auth_ok_q;           // authorization bytes matched so far
	logic [4:0]  cp_i_q;              // copy position in scratchpad
	logic [5:0]  rom_cnt_q;           // identity bits shifted into crc
	spm_byte_t   scratch_q [0:31];    // scratchpad page
	spm_byte_t   mem_q [0:8191];      // 256 pages of 32 bytes
	logic        rx_byte_done;        // last bit of a byte arrives
	spm_byte_t   rx_byte;             // byte completed this cycle
	logic        bus_rst_eff;         // bus reset that is obeyed
	logic        tx_state;            // state answers on read slots
	logic        rx_state;            // state takes write slots
	logic        push;                // bit enters the buffer
	logic        push_bit;            // bit entering the buffer
	logic        buf_in_ready;        // buffer has room
	spm_byte_t   cur_byte;            // byte being answered
	spm_byte_t   es_byte;             // status byte image
	spm_byte_t   auth_exp;            // expected authorization byte
	logic        auth_match;          // all three bytes match
	logic [13:0] sp_pos;              // scratchpad position being read
	logic [17:0] mem_addr;            // memory address being read
	logic [4:0]  wr_off;              // write offset within scratchpad
	logic [7:0]  crc_w;               // crc generator contents
	logic [55:0] rom_src;             // family code and serial number

	// memory index of a page offset relative to the target address page
	function automatic logic [12:0] page_index(input spm_byte_t hi, input spm_byte_t lo, input logic [4:0] off);
		page_index = {hi[4:0], lo[7:5], off};
	endfunction : page_index

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// a copy in flight cannot be cut short by a bus reset
	assign bus_rst_eff  = bus_reset & (state_q != SPM_COPY);
	assign rx_byte      = {rx_bit, rx_sh_q[7:1]};
	assign rx_byte_done = rx_valid & rx_state & (rx_cnt_q == 3'd7);
	assign rx_state     = (state_q == SPM_CMD) | (state_q == SPM_TA1) | (state_q == SPM_TA2)
	                    | (state_q == SPM_WDATA) | (state_q == SPM_AUTH);
	assign tx_state     = (state_q == SPM_RSCR) | (state_q == SPM_RMEM) | (state_q == SPM_DONE0);
	assign es_byte      = {aa_q, of_q, pf_q, end_q};
	assign wr_off       = wr_pos_q[4:0];
	assign rom_src      = {SERIAL_NUMBER, FAMILY_CODE};

	// receive shifter; byte boundary restarts on every bus reset
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_sh_q  <= 8'h00;
			rx_cnt_q <= 3'd0;
		end
		else if (ce)
		begin
			if (bus_rst_eff || !rx_state)
				rx_cnt_q <= 3'd0;
			else if (rx_valid)
			begin
				rx_sh_q  <= rx_byte;
				rx_cnt_q <= rx_cnt_q + 3'd1;
			end
		end
	end

	// command sequencing
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= SPM_IDLE;
			cmd_q   <= 8'h00;
		end
		else if (ce)
		begin
			if (bus_rst_eff)
				state_q <= SPM_IDLE;
			else
			begin
				unique case (state_q)
					SPM_IDLE:
						if (rom_cmd_done)
							state_q <= SPM_CMD;
					SPM_CMD:
						if (rx_byte_done)
						begin
							cmd_q <= rx_byte;
							case (rx_byte)
								`SPM_CMD_WRITE_SCR: state_q <= SPM_TA1;
								`SPM_CMD_READ_MEM:  state_q <= SPM_TA1;
								`SPM_CMD_READ_SCR:  state_q <= SPM_RSCR;
								`SPM_CMD_COPY_SCR:  state_q <= SPM_AUTH;
								default:            state_q <= SPM_HALT;
							endcase
						end
					SPM_TA1:
						if (rx_byte_done)
							state_q <= SPM_TA2;
					SPM_TA2:
						if (rx_byte_done)
							state_q <= (cmd_q == `SPM_CMD_WRITE_SCR) ? SPM_WDATA : SPM_RMEM;
					SPM_AUTH:
						if (rx_byte_done && auth_cnt_q == 2'd2)
							state_q <= auth_match ? SPM_COPY : SPM_HALT;
					SPM_COPY:
						if (cp_i_q == end_q)
							state_q <= SPM_DONE0;
					SPM_WDATA, SPM_RSCR, SPM_RMEM, SPM_DONE0, SPM_HALT:
						state_q <= state_q; // left only by a bus reset
				endcase
			end
		end
	end

	// target address registers, loaded by write scratchpad and read memory
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			target_address_low  <= `SPM_TA_RESET;
			target_address_high <= `SPM_TA_RESET;
		end
		else if (ce && !bus_rst_eff && rx_byte_done)
		begin
			if (state_q == SPM_TA1)
				target_address_low <= rx_byte;
			else if (state_q == SPM_TA2)
				target_address_high <= rx_byte;
		end
	end

	// status byte: only the device updates it, the master never writes it
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			end_q    <= `SPM_END_RESET;
			pf_q     <= 1'b0;
			of_q     <= 1'b0;
			aa_q     <= 1'b0;
			wr_pos_q <= 6'd0;
		end
		else if (ce && !bus_rst_eff)
		begin
			if (state_q == SPM_CMD && rx_byte_done && rx_byte == `SPM_CMD_WRITE_SCR)
			begin
				aa_q <= 1'b0;
				of_q <= 1'b0;
				pf_q <= 1'b0;
			end
			else if (state_q == SPM_TA2 && rx_byte_done && cmd_q == `SPM_CMD_WRITE_SCR)
			begin
				end_q    <= target_address_low[4:0];
				wr_pos_q <= {1'b0, target_address_low[4:0]};
			end
			else if (state_q == SPM_WDATA && rx_valid)
			begin
				pf_q <= (rx_cnt_q != 3'd7);
				if (wr_pos_q[5])
					of_q <= 1'b1;
				else
				begin
					end_q <= wr_off;
					if (rx_cnt_q == 3'd7)
						wr_pos_q <= wr_pos_q + 6'd1;
				end
			end
			else if (state_q == SPM_AUTH && rx_byte_done && auth_cnt_q == 2'd2 && auth_match)
				aa_q <= 1'b1;
		end
	end
	assign ending_offset_status = es_byte;

	// scratchpad fills bit by bit, so a partial byte keeps its new low bits
	always_ff @(posedge clk_sys)
	begin
		if (rst_n && ce && !bus_rst_eff && state_q == SPM_WDATA && rx_valid && !wr_pos_q[5])
			scratch_q[wr_off][rx_cnt_q] <= rx_bit;
	end

	// authorization: three bytes checked against the address and status registers
	always_comb
	begin
		auth_exp = es_byte;
		if (auth_cnt_q == 2'd0)
			auth_exp = target_address_low;
		else if (auth_cnt_q == 2'd1)
			auth_exp = target_address_high;
	end
	assign auth_match = auth_ok_q & (rx_byte == es_byte);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			auth_cnt_q <= 2'd0;
			auth_ok_q  <= 1'b0;
		end
		else if (ce)
		begin
			if (state_q != SPM_AUTH)
			begin
				auth_cnt_q <= 2'd0;
				auth_ok_q  <= 1'b1;
			end
			else if (rx_byte_done)
			begin
				auth_cnt_q <= auth_cnt_q + 2'd1;
				auth_ok_q  <= auth_ok_q & (rx_byte == auth_exp);
			end
		end
	end

	// copy walks the scratchpad one byte per cycle; whole bytes go across
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cp_i_q <= 5'd0;
		else if (ce)
		begin
			if (state_q == SPM_AUTH)
				cp_i_q <= target_address_low[4:0];
			else if (state_q == SPM_COPY)
				cp_i_q <= cp_i_q + 5'd1;
		end
	end

	// memory array; addresses beyond the last page are not written
	always_ff @(posedge clk_sys)
	begin
		if (rst_n && ce && state_q == SPM_COPY && target_address_high[7:5] == 3'd0)
			mem_q[page_index(target_address_high, target_address_low, cp_i_q)] <= scratch_q[cp_i_q];
	end

	// byte being answered on read slots
	assign sp_pos   = {9'd0, target_address_low[4:0]} + (idx_q - 14'd3);
	assign mem_addr = {2'b00, target_address_high, target_address_low} + {4'h0, idx_q};
	always_comb
	begin
		cur_byte = `SPM_BYTE_ZERO;
		if (state_q == SPM_RSCR)
		begin
			if (idx_q == 14'd0)
				cur_byte = target_address_low;
			else if (idx_q == 14'd1)
				cur_byte = target_address_high;
			else if (idx_q == `SPM_HDR_LAST)
				cur_byte = es_byte;
			else if (sp_pos > {9'd0, `SPM_SCR_LAST})
				cur_byte = `SPM_BYTE_ONES;
			else
				cur_byte = scratch_q[sp_pos[4:0]];
		end
		else if (state_q == SPM_RMEM)
		begin
			if (mem_addr >= `SPM_MEM_BYTES)
				cur_byte = `SPM_BYTE_ONES;
			else
				cur_byte = mem_q[mem_addr[12:0]];
		end
	end
	assign push_bit = cur_byte[tx_cnt_q];
	assign push     = tx_state & buf_in_ready;

	// answer stream position; the index saturates so a long memory read never wraps
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_cnt_q <= 3'd0;
			idx_q    <= 14'd0;
		end
		else if (ce)
		begin
			if (!tx_state || bus_rst_eff)
			begin
				tx_cnt_q <= 3'd0;
				idx_q    <= 14'd0;
			end
			else if (push)
			begin
				tx_cnt_q <= tx_cnt_q + 3'd1;
				if (tx_cnt_q == 3'd7 && idx_q != 14'h3FFF)
					idx_q <= idx_q + 14'd1;
			end
		end
	end

	// bits wait here for read slots; a bus reset drops what was queued
	spm_buf2 #(
		.WIDTH (1)
	) u_txbuf (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.ce        (ce),
		.flush     (bus_rst_eff),
		.in_valid  (tx_state),
		.in_data   (push_bit),
		.in_ready  (buf_in_ready),
		.out_valid (tx_valid),
		.out_data  (tx_bit),
		.out_ready (tx_ready)
	);

	// speed: regular after reset, overdrive only when switched from regular
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			speed_select_flag <= 1'b0;
		else if (ce)
		begin
			if (bus_rst_eff && bus_reset_slow)
				speed_select_flag <= 1'b0;
			else if (rom_od_cmd && !speed_select_flag)
				speed_select_flag <= 1'b1;
		end
	end

	// identity rom: crc is built once after reset from family and serial
	spm_crc8 u_crc (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.shift   (rom_cnt_q != `SPM_ROM_DATA_BITS),
		.din     (rom_src[rom_cnt_q]),
		.crc_q   (crc_w)
	);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rom_cnt_q <= 6'd0;
			rom_code  <= 64'h0000_0000_0000_0000;
			rom_valid <= 1'b0;
		end
		else if (ce)
		begin
			if (rom_cnt_q != `SPM_ROM_DATA_BITS)
				rom_cnt_q <= rom_cnt_q + 6'd1;
			else if (!rom_valid)
			begin
				rom_code  <= {crc_w, rom_src};
				rom_valid <= 1'b1;
			end
		end
	end

	property p_od_switch;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && rom_od_cmd && !speed_select_flag && !(bus_rst_eff && bus_reset_slow)) |=> speed_select_flag;
	endproperty
	a_od_switch: assert property (p_od_switch) else $error("overdrive not entered");

	property p_aa_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && !bus_rst_eff && state_q == SPM_CMD && rx_byte_done && rx_byte == `SPM_CMD_WRITE_SCR)
		|=> !ending_offset_status[`SPM_ES_AA_BIT] ##1 (state_q == SPM_TA1 || !ce || bus_reset);
	endproperty
	a_aa_clear: assert property (p_aa_clear) else $error("copied flag survived a write");

	property p_rom_gate;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_q == SPM_IDLE && !rom_cmd_done) |=> (state_q == SPM_IDLE);
	endproperty
	a_rom_gate: assert property (p_rom_gate) else $error("memory command taken without rom command");

	property p_copy_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && state_q == SPM_COPY && bus_reset) |=> (state_q == SPM_COPY || state_q == SPM_DONE0);
	endproperty
	a_copy_hold: assert property (p_copy_hold) else $error("bus reset broke a copy");

	property p_ones_scr;
		@(posedge clk_sys) disable iff (!rst_n)
		(push && state_q == SPM_RSCR && idx_q > 14'd34) |-> push_bit;
	endproperty
	a_ones_scr: assert property (p_ones_scr) else $error("read past scratchpad not ones");

	property p_ones_mem;
		@(posedge clk_sys) disable iff (!rst_n)
		(push && state_q == SPM_RMEM && mem_addr[17:13] != 5'd0) |-> push_bit;
	endproperty
	a_ones_mem: assert property (p_ones_mem) else $error("read past memory not ones");

	property p_zero_done;
		@(posedge clk_sys) disable iff (!rst_n)
		(push && state_q == SPM_DONE0) |-> !push_bit;
	endproperty
	a_zero_done: assert property (p_zero_done) else $error("nonzero bit after copy");

	property p_mismatch;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && !bus_rst_eff && state_q == SPM_AUTH && rx_byte_done && auth_cnt_q == 2'd2 && !auth_match)
		|=> (state_q == SPM_HALT) && $stable(ending_offset_status);
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatched copy changed state");

	property p_end_off;
		@(posedge clk_sys) disable iff (!rst_n)
		(ce && !bus_rst_eff && state_q == SPM_WDATA && rx_valid && !wr_pos_q[5]) |=> (end_q == $past(wr_off));
	endproperty
	a_end_off: assert property (p_end_off) else $error("ending offset not tracking writes");

	property p_rom_crc;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(rom_valid) |-> (rom_code[63:56] == crc_w) && (rom_code[55:0] == rom_src);
	endproperty
	a_rom_crc: assert property (p_rom_crc) else $error("identity rom layout wrong");

endmodule : spm_top
`default_nettype wire

/* test/spm_master.sv */
// bus master model: slot layer bits to and from the device
`timescale 1ns/1ps
`default_nettype none

module spm_master (
	input  wire logic clk_sys,  // system clock
	input  wire logic tx_valid, // device offers a bit
	input  wire logic tx_bit,   // offered bit
	output var  logic rx_valid, // master write slot
	output var  logic rx_bit,   // written bit
	output var  logic tx_ready  // master read slot
);
	bit slow  = 1'b0; // stall read slots at random
	int taken = 0;    // bits read so far

	// idle slots at time zero
	initial
	begin
		rx_valid = 1'b0;
		rx_bit   = 1'b0;
		tx_ready = 1'b0;
	end

	// n bits of b, lsb first; a released line shows the inverse level
	task automatic send(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk_sys);
			rx_valid = 1'b1;
			rx_bit   = b[i];
		end
		@(negedge clk_sys);
		rx_valid = 1'b0;
		rx_bit   = !rx_bit;
	endtask : send

	// one byte, lsb first; each bit waits at most lim slots, a miss stays unknown
	task automatic recv(output logic [7:0] b, input int lim);
		b = 8'hxx;
		for (int i = 0; i < 8; i++)
		begin
			for (int w = 0; w < lim; w++)
			begin
				@(negedge clk_sys);
				tx_ready = !slow || $urandom_range(1);
				@(posedge clk_sys);
				if (tx_ready && tx_valid)
				begin
					b[i] = tx_bit;
					taken++;
					break;
				end
			end
		end
		@(negedge clk_sys);
		tx_ready = 1'b0;
	endtask : recv
endmodule : spm_master
`default_nettype wire

/* test/tb_top.sv */
// testbench for the scratchpad memory command logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t %h %h", $time, a, b); end end

module tb_top;
	localparam logic [7:0]  FAM = 8'h3C;           // arbitrary value
	localparam logic [47:0] SER = 48'h1357_9BDF_2468; // arbitrary value
	logic        clk_sys = 1'b0;
	logic        rst_b, ce, bus_reset, bus_reset_slow, rom_cmd_done, rom_od_cmd;
	logic        rx_valid, rx_bit, tx_ready, tx_valid, tx_bit, speed_select_flag, rom_valid;
	logic [7:0]  target_address_low, target_address_high, ending_offset_status;
	logic [63:0] rom_code;
	logic [7:0]  sp [32]; // model of the scratchpad contents
	int          failures = 0;
	int          checks_done = 0;

	always #4 clk_sys = !clk_sys;

	spm_top #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER)) u_spm_top (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
		.bus_reset(bus_reset), .bus_reset_slow(bus_reset_slow), .rom_cmd_done(rom_cmd_done),
		.rom_od_cmd(rom_od_cmd), .rx_valid(rx_valid), .rx_bit(rx_bit), .tx_ready(tx_ready),
		.tx_valid(tx_valid), .tx_bit(tx_bit), .speed_select_flag(speed_select_flag),
		.target_address_low(target_address_low), .target_address_high(target_address_high),
		.ending_offset_status(ending_offset_status), .rom_code(rom_code), .rom_valid(rom_valid));
	spm_master u_spm_master (.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_bit(tx_bit), .rx_valid(rx_valid),
		.rx_bit(rx_bit), .tx_ready(tx_ready));

	// reflected x8+x5+x4+1 over the first n bits, from zero
	function automatic logic [7:0] crc_of(input logic [63:0] v, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n; i++)
			c = (c >> 1) ^ (((c[0] ^ v[i]) == 1'b1) ? 8'h8C : 8'h00);
		return c;
	endfunction : crc_of

	// status after writing n bytes (plus a partial one) from off
	function automatic logic [7:0] es_of(input logic [4:0] off, input int n, input bit pf);
		int e;
		e = off + n - (pf ? 0 : 1);
		return (e > 31) ? 8'h5F : {2'b00, pf, 5'(e)};
	endfunction : es_of

	// bus reset; unless slow_rst, rom command done, then a memory command
	task automatic start(input logic [7:0] cmd, input bit slow_rst);
		@(negedge clk_sys);
		bus_reset      = 1'b1;
		bus_reset_slow = slow_rst;
		@(negedge clk_sys);
		bus_reset      = 1'b0;
		bus_reset_slow = 1'b0;
		rom_cmd_done   = slow_rst ? 1'b0 : 1'b1;
		@(negedge clk_sys);
		rom_cmd_done = 1'b0;
		if (!slow_rst)
			u_spm_master.send(cmd, 8);
	endtask : start

	// read one byte and compare
	task automatic rx_chk(input logic [7:0] e);
		logic [7:0] b;
		u_spm_master.recv(b, 100);
		`CHK(b, e)
	endtask : rx_chk

	// no read slot may be answered
	task automatic silent();
		logic [7:0] b;
		int         t0;
		t0 = u_spm_master.taken;
		u_spm_master.recv(b, 3);
		`CHK(u_spm_master.taken, t0)
	endtask : silent

	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	// hang guard, far beyond the expected few thousand cycles
	initial
	begin
		#400_000;
		failures++;
		stop_test();
	end

	initial
	begin
		logic [7:0] tl, th, es_x, b;
		logic [4:0] off;
		int         n;
		bit         pf;
		void'($urandom(73));
		{rst_b, ce, bus_reset, bus_reset_slow, rom_cmd_done, rom_od_cmd} = 6'b01_0000;
		repeat (5) @(negedge clk_sys);
		rst_b = 1'b1;
		for (int i = 0; i < 200 && rom_valid !== 1'b1; i++)
			@(negedge clk_sys);
		`CHK({rom_valid, rom_code[55:0]}, {1'b1, SER, FAM})
		`CHK(rom_code[63:56], crc_of({8'h00, SER, FAM}, 56))
		`CHK(crc_of(rom_code, 64), 8'h00)
		`CHK(speed_select_flag, 1'b0)
		ce         = 1'b0;
		rom_od_cmd = 1'b1;
		@(negedge clk_sys);
		`CHK(speed_select_flag, 1'b0)
		ce = 1'b1;
		@(negedge clk_sys);
		rom_od_cmd = 1'b0;
		`CHK(speed_select_flag, 1'b1)
		start(8'h00, 1'b1);
		`CHK(speed_select_flag, 1'b0)
		// round 0 overflows, round 1 ends in a partial byte, rounds 2 and 3 copy
		for (int k = 0; k < 4; k++)
		begin
			pf   = (k == 1);
			off  = (k == 0) ? 5'h00 : (k == 2) ? 5'h1C : 5'($urandom_range(pf ? 15 : 31));
			n    = (k == 0) ? 33 : $urandom_range(pf ? 8 : 32 - off, 1);
			tl   = {3'($urandom), off};
			th   = 8'($urandom_range(31));
			u_spm_master.slow = k[0];
			start(8'h0F, 1'b0);
			u_spm_master.send(tl, 8);
			u_spm_master.send(th, 8);
			for (int j = 0; j < n; j++)
			begin
				b = 8'($urandom);
				if (off + j < 32)
					sp[off + j] = b;
				u_spm_master.send(b, 8);
			end
			// a partial byte replaces only its low bits
			if (pf)
			begin
				b = 8'($urandom);
				sp[off + n][2:0] = b[2:0];
				u_spm_master.send(b, 3);
			end
			repeat (3) @(negedge clk_sys);
			es_x = es_of(off, n, pf);
			`CHK(ending_offset_status, es_x)
			`CHK({target_address_high, target_address_low}, {th, tl})
			start(8'hAA, 1'b0);
			rx_chk(tl);
			rx_chk(th);
			rx_chk(es_x);
			for (int j = 0; j < 32 - off; j++)
				rx_chk(sp[off + j]);
			rx_chk(8'hFF);
			if (k > 1)
			begin
				start(8'h55, 1'b0);
				u_spm_master.send(tl, 8);
				u_spm_master.send(th, 8);
				u_spm_master.send(es_x, 8);
				// a bus reset while the copy runs must be ignored
				bus_reset = 1'b1;
				@(negedge clk_sys);
				bus_reset = 1'b0;
				rx_chk(8'h00);
				`CHK(ending_offset_status, es_x | 8'h80)
				start(8'hF0, 1'b0);
				u_spm_master.send(tl, 8);
				u_spm_master.send(th, 8);
				for (int j = 0; j < n; j++)
					rx_chk(sp[off + j]);
				`CHK(ending_offset_status, es_x | 8'h80)
			end
		end
		start(8'h55, 1'b0);
		u_spm_master.send(tl, 8);
		u_spm_master.send(th, 8);
		u_spm_master.send((es_x | 8'h80) ^ 8'h01, 8);
		silent();
		`CHK(ending_offset_status, es_x | 8'h80)
		start(8'h3C, 1'b0);
		silent();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
